//--- dv/lin_node_model.sv
// Remote LIN node model: pulls the serial line low for a commanded length.
// Assumes the bench pulses send for one cycle with low_len held steady.
`timescale 1ns/1ps
module lin_node_model
(
	input  wire logic       clk,
	input  wire logic       send,
	input  wire logic [9:0] low_len,
	output logic            line
);
	logic [9:0] left = 10'h000;

	////////////////////////////////////////////////////////////////////////
	// Low-time counter
	always_ff @(posedge clk) begin
		if (send) begin
			left <= low_len;
		end else if (left != 10'h000) begin
			left <= left - 10'h001;
		end
	end

	// Released line returns to the pull-up level
	assign line = (left == 10'h000);
endmodule // lin_node_model

//--- dv/test_lin_brk_ctrl.sv
// Self-checking bench for the baud, break-field and pin control block.
// Assumes the design package and the remote node model are compiled first.
`timescale 1ns/1ps
module test_lin_brk_ctrl;
	import lin_brk_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic        wr_en = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        rd_en = 1'b0;
	logic [7:0]  rdata;
	logic        shift_tx_data = 1'b1;
	logic        shift_tx_done = 1'b0;
	logic        gpio_tx_latch = 1'b0;
	logic        ext_int_pin = 1'b1;
	logic        capture_pin = 1'b1;
	logic        node_send = 1'b0;
	logic [9:0]  node_len = 10'h000;
	logic        rx_pin, tx_pin_o, tx_pin_oe, rx_serial, ext_int_out, capture_out;
	logic        baud_tick, bit_order_lsb, tx_active, rx_active, dali_mode;
	logic        tx_done_int, rx_break_done;
	int          n_fail = 0;
	int          total_checks = 0;

	always #2 clock = ~clock;

	lin_brk_ctrl u_dut (.CLOCK(clock), .RST(rst), .ADDR(addr), .WR_EN(wr_en),
		.WDATA(wdata), .RD_EN(rd_en), .RDATA(rdata), .SHIFT_TX_DATA(shift_tx_data),
		.SHIFT_TX_DONE(shift_tx_done), .GPIO_TX_LATCH(gpio_tx_latch), .RX_PIN_I(rx_pin),
		.EXT_INT_PIN(ext_int_pin), .CAPTURE_PIN(capture_pin), .TX_PIN_O(tx_pin_o),
		.TX_PIN_OE(tx_pin_oe), .RX_SERIAL(rx_serial), .EXT_INT_OUT(ext_int_out),
		.CAPTURE_OUT(capture_out), .BAUD_TICK(baud_tick), .BIT_ORDER_LSB(bit_order_lsb),
		.TX_ACTIVE(tx_active), .RX_ACTIVE(rx_active), .DALI_MODE(dali_mode),
		.TX_DONE_INT(tx_done_int), .RX_BREAK_DONE(rx_break_done));

	lin_node_model u_node (.clk(clock), .send(node_send), .low_len(node_len), .line(rx_pin));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic give_verdict;
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clock);
		wr_en = 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clock);
		addr = a;
		rd_en = 1'b1;
		@(negedge clock);
		rd_en = 1'b0;
		chk(rdata, exp);
	endtask

	task automatic node_break(input logic [9:0] len);
		@(negedge clock);
		node_len = len;
		node_send = 1'b1;
		@(negedge clock);
		node_send = 1'b0;
	endtask

	task automatic set_baud(input logic [7:0] sel, input logic [7:0] div, input logic [7:0] dali);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CLK_SEL, sel);
		wr(ADDR_BAUD_DIV, div);
		wr(ADDR_DALI_CTRL, dali);
		wr(ADDR_MODE, 8'h80);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset_values;
		rdchk(ADDR_PORT_DIR, 8'hFF);
		rdchk(ADDR_SRC_SWITCH, 8'h00);
		rdchk(ADDR_MODE, 8'h01);
		rdchk(ADDR_BAUD_DIV, 8'hFF);
		rdchk(ADDR_LIN_CTRL, 8'h16);
		rdchk(ADDR_PORT_OTYPE, 8'h00);
		rdchk(16'hFF00, 8'h00);
		chk(8'(tx_pin_oe), 8'h00);
		chk(8'(bit_order_lsb), 8'h01);
		chk({5'h00, tx_active, rx_active, dali_mode}, 8'h00);
	endtask

	task automatic t_baud;
		logic [7:0] sel [6] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
		logic [7:0] div [6] = '{8'h04, 8'h02, 8'h05, 8'h04, 8'hFF, 8'h04};
		logic [7:0] dal [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		int         per [6] = '{8, 8, 20, 32, 510, 16};
		int         c, i, n;
		for (c = 0; c < 6; c++) begin
			set_baud(sel[c], div[c], dal[c]);
			for (i = 0; i < 3000 && baud_tick !== 1'b1; i++) @(negedge clock);
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (baud_tick !== 1'b1 && n < 3000);
			chk(8'(n / 2), 8'(per[c] / 2));
		end
	endtask

	task automatic t_break_tx;
		int code, i, ticks;
		logic inv;
		int blen [8] = '{16, 17, 18, 19, 20, 13, 14, 15};
		set_baud(8'h00, 8'h04, 8'h00);
		wr(ADDR_PORT_DIR, 8'hFE);
		gpio_tx_latch = 1'b1;
		wr(ADDR_MODE, 8'hC0);
		shift_tx_data = 1'b0;
		shift_tx_done = 1'b1;
		#1;
		chk(8'(tx_done_int), 8'h01);
		repeat (3) @(negedge clock);
		chk({6'h00, tx_pin_oe, tx_pin_o}, 8'h02);
		shift_tx_data = 1'b1;
		shift_tx_done = 1'b0;
		for (code = 0; code < 9; code++) begin
			inv = (code == 8);
			if (inv) begin
				wr(ADDR_MODE, 8'h80);
				wr(ADDR_LIN_CTRL, 8'h03);
				wr(ADDR_MODE, 8'hC0);
				repeat (3) @(negedge clock);
				chk(8'(tx_pin_o), 8'h00);
			end
			wr(ADDR_LIN_CTRL, {3'b001, code[2:0], 1'b1, inv});
			ticks = int'(baud_tick === 1'b1);
			for (i = 0; i < 400 && tx_done_int !== 1'b1; i++) begin
				@(negedge clock);
				if (baud_tick === 1'b1) ticks++;
				if (i == 8) chk(8'(tx_pin_o), 8'(inv));
			end
			chk(8'(ticks), 8'(blen[code[2:0]]));
			rdchk(ADDR_LIN_CTRL, {3'b000, code[2:0], 1'b1, inv});
		end
	endtask

	task automatic t_break_rx;
		int i;
		wr(ADDR_MODE, 8'h80);
		wr(ADDR_LIN_CTRL, 8'h02);
		wr(ADDR_MODE, 8'hA0);
		wr(ADDR_LIN_CTRL, 8'h42);
		rdchk(ADDR_LIN_CTRL, 8'h82);
		node_break(10'd40);
		for (i = 0; i < 100; i++) begin
			@(negedge clock);
			if (rx_break_done === 1'b1) chk(8'h01, 8'h00);
		end
		rdchk(ADDR_LIN_CTRL, 8'h82);
		node_break(10'd120);
		for (i = 0; i < 300 && rx_break_done !== 1'b1; i++) @(negedge clock);
		chk(8'(rx_break_done), 8'h01);
		rdchk(ADDR_LIN_CTRL, 8'h02);
		wr(ADDR_LIN_CTRL, 8'h42);
		wr(ADDR_MODE, 8'h00);
		rdchk(ADDR_LIN_CTRL, 8'h02);
		node_break(10'd40);
		repeat (4) @(negedge clock);
		chk(8'(rx_serial), 8'h01);
	endtask

	task automatic t_pins;
		wr(ADDR_MODE, 8'h80);
		wr(ADDR_SRC_SWITCH, 8'h01);
		node_break(10'd40);
		repeat (8) @(negedge clock);
		chk({5'h00, rx_serial, capture_out, ext_int_out}, 8'h02);
		wr(ADDR_SRC_SWITCH, 8'h02);
		node_break(10'd40);
		repeat (8) @(negedge clock);
		chk({6'h00, capture_out, ext_int_out}, 8'h01);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_LIN_CTRL, 8'h02);
		gpio_tx_latch = 1'b0;
		repeat (3) @(negedge clock);
		chk({6'h00, tx_pin_oe, tx_pin_o}, 8'h02);
		gpio_tx_latch = 1'b1;
		wr(ADDR_LIN_CTRL, 8'h03);
		repeat (3) @(negedge clock);
		chk(8'(tx_pin_o), 8'h00);
		wr(ADDR_LIN_CTRL, 8'h00);
		repeat (2) @(negedge clock);
		chk(8'(bit_order_lsb), 8'h00);
		wr(ADDR_PORT_OTYPE, 8'h01);
		repeat (2) @(negedge clock);
		chk({6'h00, tx_pin_oe, tx_pin_o}, 8'h01);
		wr(ADDR_PORT_OTYPE, 8'h00);
	endtask

	task automatic t_dali;
		int i;
		set_baud(8'h00, 8'h04, 8'h01);
		wr(ADDR_LIN_CTRL, 8'h02);
		wr(ADDR_MODE, 8'hE0);
		chk({5'h00, tx_active, rx_active, dali_mode}, 8'h07);
		wr(ADDR_LIN_CTRL, 8'h62);
		rdchk(ADDR_LIN_CTRL, 8'h02);
		chk(8'(bit_order_lsb), 8'h00);
		for (i = 0; i < 400; i++) begin
			@(negedge clock);
			if (tx_done_int === 1'b1 || tx_pin_o !== 1'b1) chk(8'h01, 8'h00);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(negedge clock);
		rst = 1'b0;
		t_reset_values();
		t_baud();
		t_break_tx();
		t_break_rx();
		t_pins();
		t_dali();
		give_verdict();
	end
endmodule // test_lin_brk_ctrl

//--- verilog/baud_rate_gen.sv
// Base clock prescaler, 8-bit divisor counter and bit-rate divider.
// Assumes run is low whenever the unit is powered down.
`timescale 1ns/1ps
module baud_rate_gen
	import lin_brk_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [3:0] base_sel,
	input  wire logic [7:0] divisor,
	input  wire logic       dali,
	output logic            cnt_tick,
	output logic            bit_tick
);
	logic [9:0] pre;
	logic [7:0] cnt;
	logic [7:0] k;
	logic [1:0] half;
	logic       base_tick;

	function automatic logic base_hit(input logic [9:0] p, input logic [3:0] sel);
		logic [9:0] mask;
		mask = 10'h000;
		for (int i = 0; i < 10; i++) begin
			mask[i] = (sel > CLK_SEL_MAX) ? 1'b1 : (4'(i) < sel);
		end
		return (p & mask) == mask;
	endfunction

	///////////////////////////////////////////////////////////////////////////
	assign base_tick = run && base_hit(pre, base_sel);
	assign k         = (divisor < DIV_MIN) ? DIV_MIN : divisor;
	assign cnt_tick  = base_tick && (cnt == k - 8'h01);
	assign bit_tick  = cnt_tick && (dali ? (half == 2'h3) : half[0]);

	always_ff @(posedge clk) begin
		if (rst || !run) begin
			pre <= 10'h000;
		end else begin
			pre <= pre + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt <= 8'h00;
		end else if (cnt_tick) begin
			cnt <= 8'h00;
		end else if (base_tick) begin
			cnt <= cnt + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !run) begin
			half <= 2'h0;
		end else if (cnt_tick) begin
			half <= half + 2'h1;
		end
	end
endmodule // baud_rate_gen

//--- verilog/lin_brk_ctrl.sv
// Baud generation, LIN break-field send and receive, and serial pin control.
// Assumes the frame shifter, status registers and DALI framing sit outside.
`timescale 1ns/1ps
module lin_brk_ctrl
(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic [15:0] ADDR,
	input  wire logic        WR_EN,
	input  wire logic [7:0]  WDATA,
	input  wire logic        RD_EN,
	output logic [7:0]       RDATA,
	input  wire logic        SHIFT_TX_DATA,
	input  wire logic        SHIFT_TX_DONE,
	input  wire logic        GPIO_TX_LATCH,
	input  wire logic        RX_PIN_I,
	input  wire logic        EXT_INT_PIN,
	input  wire logic        CAPTURE_PIN,
	output logic             TX_PIN_O,
	output logic             TX_PIN_OE,
	output logic             RX_SERIAL,
	output logic             EXT_INT_OUT,
	output logic             CAPTURE_OUT,
	output logic             BAUD_TICK,
	output logic             BIT_ORDER_LSB,
	output logic             TX_ACTIVE,
	output logic             RX_ACTIVE,
	output logic             DALI_MODE,
	output logic             TX_DONE_INT,
	output logic             RX_BREAK_DONE
);
	import lin_brk_pkg::*;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_WAIT = 2'b01,
		RX_MEAS = 2'b10
	} rx_state_e;

	logic [7:0] port_direction;
	logic [7:0] input_source_switch;
	logic [7:0] mode_ctrl;
	logic [7:0] clock_select;
	logic [7:0] baud_divisor_ctrl;
	logic [7:0] lin_break_ctrl;
	logic [7:0] dali_ctrl;
	logic [7:0] port_output_type;

	logic       rx_meta;
	logic       rx_sync;
	logic       ext_meta;
	logic       ext_sync;
	logic       cap_meta;
	logic       cap_sync;

	logic       power;
	logic       txe;
	logic       rxe;
	logic       dali;
	logic       inv_eff;
	logic       cnt_tick;
	logic       bit_tick;
	logic       wr_lin;
	logic       rx_trig_wr;
	logic       tx_trig_wr;

	logic       tx_brk;
	logic [4:0] tx_cnt;
	logic [4:0] tx_len;
	logic       tx_brk_end;
	rx_state_e  rx_state;
	logic [4:0] rx_cnt;
	logic       rx_line;
	logic       rx_ok;
	logic       rx_err;
	logic       rx_status;
	logic       serial_level;
	logic       next_pin_o;
	logic       next_pin_oe;
	logic [7:0] next_rdata;

	function automatic logic [4:0] brk_bits(input logic [2:0] code);
		return (code >= BRK_LEN_WRAP) ? BRK_LEN_LOW + 5'(code) : BRK_LEN_HIGH + 5'(code);
	endfunction

	///////////////////////////////////////////////////////////////////////////
	// Control decode
	assign power      = mode_ctrl[MODE_POWER];
	assign txe        = power && mode_ctrl[MODE_TXE];
	assign rxe        = power && mode_ctrl[MODE_RXE];
	assign dali       = dali_ctrl[DALI_SEL];
	assign inv_eff    = lin_break_ctrl[LIN_INV] && !dali;
	assign wr_lin     = WR_EN && (ADDR == ADDR_LIN_CTRL);
	assign rx_trig_wr = wr_lin && WDATA[LIN_RX_TRIG] && rxe && !dali;
	assign tx_trig_wr = wr_lin && WDATA[LIN_TX_TRIG] && txe && !dali;
	assign tx_len     = brk_bits(lin_break_ctrl[LIN_LEN_LSB +: 3]);
	assign rx_status  = (rx_state != RX_IDLE) && !dali;

	///////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			port_direction      <= RST_PORT_DIR;
			input_source_switch <= RST_SRC_SWITCH;
			mode_ctrl           <= RST_MODE;
			clock_select        <= RST_CLK_SEL;
			baud_divisor_ctrl   <= RST_BAUD_DIV;
			dali_ctrl           <= RST_DALI_CTRL;
			port_output_type    <= RST_PORT_OTYPE;
		end else if (WR_EN) begin
			case (ADDR)
				ADDR_PORT_DIR:   port_direction      <= {6'h3F, WDATA[1:0]};
				ADDR_SRC_SWITCH: input_source_switch <= {6'h00, WDATA[1:0]};
				ADDR_MODE:       mode_ctrl           <= WDATA;
				ADDR_CLK_SEL:    clock_select        <= {4'h0, WDATA[3:0]};
				ADDR_BAUD_DIV:   baud_divisor_ctrl   <= WDATA;
				ADDR_DALI_CTRL:  dali_ctrl           <= {7'h00, WDATA[0]};
				ADDR_PORT_OTYPE: port_output_type    <= {6'h00, WDATA[1:0]};
				default: ;
			endcase
		end
	end

	// Trigger bits are not stored; only length, order and invert are
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			lin_break_ctrl <= RST_LIN_CTRL;
		end else if (wr_lin) begin
			lin_break_ctrl <= {3'h0, WDATA[4:0]};
		end
	end

	always_comb begin
		case (ADDR)
			ADDR_PORT_DIR:   next_rdata = port_direction;
			ADDR_SRC_SWITCH: next_rdata = input_source_switch;
			ADDR_MODE:       next_rdata = mode_ctrl;
			ADDR_CLK_SEL:    next_rdata = clock_select;
			ADDR_BAUD_DIV:   next_rdata = baud_divisor_ctrl;
			ADDR_LIN_CTRL:   next_rdata = {rx_status, lin_break_ctrl[6:0]};
			ADDR_DALI_CTRL:  next_rdata = dali_ctrl;
			ADDR_PORT_OTYPE: next_rdata = port_output_type;
			default:         next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (RD_EN) begin
			RDATA <= next_rdata;
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rx_meta  <= 1'b1;
			rx_sync  <= 1'b1;
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			cap_meta <= 1'b0;
			cap_sync <= 1'b0;
		end else begin
			rx_meta  <= RX_PIN_I;
			rx_sync  <= rx_meta;
			ext_meta <= EXT_INT_PIN;
			ext_sync <= ext_meta;
			cap_meta <= CAPTURE_PIN;
			cap_sync <= cap_meta;
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// Baud generator
	baud_rate_gen u_baud (
		.clk      (CLOCK),
		.rst      (RST),
		.run      (power),
		.base_sel (clock_select[3:0]),
		.divisor  (baud_divisor_ctrl),
		.dali     (dali),
		.cnt_tick (cnt_tick),
		.bit_tick (bit_tick)
	);

	///////////////////////////////////////////////////////////////////////////
	// Break transmit
	assign tx_brk_end = tx_brk && bit_tick && (tx_cnt == tx_len - 5'h01);

	always_ff @(posedge CLOCK) begin
		if (RST || !txe || dali) begin
			tx_brk <= 1'b0;
			tx_cnt <= 5'h00;
		end else if (tx_trig_wr) begin
			tx_brk <= 1'b1;
			tx_cnt <= 5'h00;
		end else if (tx_brk_end) begin
			tx_brk <= 1'b0;
			tx_cnt <= 5'h00;
		end else if (tx_brk && bit_tick) begin
			tx_cnt <= tx_cnt + 5'h01;
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// Break receive
	assign rx_line = power ? rx_sync : 1'b1;
	assign rx_ok   = (rx_state == RX_MEAS) && rx_line && (rx_cnt >= BRK_RX_MIN);
	assign rx_err  = (rx_state == RX_MEAS) && rx_line && (rx_cnt < BRK_RX_MIN);

	always_ff @(posedge CLOCK) begin
		if (RST || !rxe || dali) begin
			rx_state <= RX_IDLE;
			rx_cnt   <= 5'h00;
		end else if (rx_trig_wr) begin
			rx_state <= RX_WAIT;
			rx_cnt   <= 5'h00;
		end else begin
			case (rx_state)
				RX_WAIT: begin
					if (!rx_line) begin
						rx_state <= RX_MEAS;
					end
					rx_cnt <= 5'h00;
				end
				RX_MEAS: begin
					if (rx_ok) begin
						rx_state <= RX_IDLE;
					end else if (rx_err) begin
						rx_state <= RX_WAIT;
					end else if (bit_tick && rx_cnt != 5'h1F) begin
						rx_cnt <= rx_cnt + 5'h01;
					end
				end
				RX_IDLE: rx_cnt <= 5'h00;
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// Pin multiplexing
	assign serial_level = !txe ? 1'b1 : (tx_brk ? 1'b0 : SHIFT_TX_DATA);

	always_comb begin
		if (txe || inv_eff) begin
			next_pin_o = serial_level ^ inv_eff;
		end else begin
			next_pin_o = GPIO_TX_LATCH;
		end
		next_pin_oe = !port_direction[PIN_TX] &&
			(!port_output_type[PIN_TX] || !next_pin_o);
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			TX_PIN_O      <= 1'b1;
			TX_PIN_OE     <= 1'b0;
			RX_SERIAL     <= 1'b1;
			EXT_INT_OUT   <= 1'b0;
			CAPTURE_OUT   <= 1'b0;
			BIT_ORDER_LSB <= 1'b1;
		end else begin
			TX_PIN_O      <= next_pin_o;
			TX_PIN_OE     <= next_pin_oe;
			RX_SERIAL     <= rx_line;
			EXT_INT_OUT   <= input_source_switch[SRC_EXT_INT] ? rx_sync : ext_sync;
			CAPTURE_OUT   <= input_source_switch[SRC_CAPTURE] ? rx_sync : cap_sync;
			BIT_ORDER_LSB <= lin_break_ctrl[LIN_DIR] && !dali;
		end
	end

	assign BAUD_TICK     = bit_tick;
	assign TX_ACTIVE     = txe;
	assign RX_ACTIVE     = rxe;
	assign DALI_MODE     = dali;
	assign TX_DONE_INT   = tx_brk_end || SHIFT_TX_DONE;
	assign RX_BREAK_DONE = rx_ok;

	///////////////////////////////////////////////////////////////////////////
	// Checks
	property p_dali_status;
		@(posedge CLOCK) disable iff (RST)
		(RD_EN && ADDR == ADDR_LIN_CTRL && dali) |=> !RDATA[LIN_RX_STAT];
	endproperty
	a_dali_status: assert property (p_dali_status) else $error("status set in DALI");

	property p_inv_owns;
		@(posedge CLOCK) disable iff (RST)
		(inv_eff && !txe && !port_direction[PIN_TX] && !port_output_type[PIN_TX])
			|=> (TX_PIN_O == 1'b0);
	endproperty
	a_inv_owns: assert property (p_inv_owns) else $error("gpio on inverted pin");

	property p_brk_low;
		@(posedge CLOCK) disable iff (RST)
		(tx_brk && txe && !inv_eff) |=> (TX_PIN_O == 1'b0);
	endproperty
	a_brk_low: assert property (p_brk_low) else $error("break not low");

	property p_bit_tick;
		@(posedge CLOCK) disable iff (RST)
		bit_tick |=> !bit_tick [*7];
	endproperty
	a_bit_tick: assert property (p_bit_tick) else $error("bit ticks too close");

	property p_tx_end;
		@(posedge CLOCK) disable iff (RST)
		(tx_brk_end && !tx_trig_wr) |-> TX_DONE_INT ##1 !tx_brk;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("break end miscounted");

	property p_rx_err;
		@(posedge CLOCK) disable iff (RST)
		(rx_err && !rx_trig_wr && rxe && !dali) |=> (rx_state == RX_WAIT) && rx_status;
	endproperty
	a_rx_err: assert property (p_rx_err) else $error("error lost status");

	property p_rx_ok;
		@(posedge CLOCK) disable iff (RST)
		(rx_ok && !rx_trig_wr && rxe && !dali) |=> !rx_status;
	endproperty
	a_rx_ok: assert property (p_rx_ok) else $error("status kept after break");

	property p_trig_read;
		@(posedge CLOCK) disable iff (RST)
		(RD_EN && ADDR == ADDR_LIN_CTRL) |=> (RDATA[6:5] == 2'b00);
	endproperty
	a_trig_read: assert property (p_trig_read) else $error("trigger read 1");

	property p_order;
		@(posedge CLOCK) disable iff (RST)
		##1 (BIT_ORDER_LSB == ($past(lin_break_ctrl[LIN_DIR]) && !$past(dali)));
	endproperty
	a_order: assert property (p_order) else $error("bit order wrong");

	property p_isc;
		@(posedge CLOCK) disable iff (RST)
		input_source_switch[SRC_EXT_INT] |=> (EXT_INT_OUT == $past(rx_sync));
	endproperty
	a_isc: assert property (p_isc) else $error("interrupt source wrong");

	property p_off;
		@(posedge CLOCK) disable iff (RST)
		!power |=> (rx_state == RX_IDLE) && !tx_brk;
	endproperty
	a_off: assert property (p_off) else $error("power off not reset");

	c_tx_brk: cover property (@(posedge CLOCK) disable iff (RST) tx_brk_end);
	c_rx_ok: cover property (@(posedge CLOCK) disable iff (RST) rx_ok);
	c_rx_err: cover property (@(posedge CLOCK) disable iff (RST) rx_err);
	c_restart: cover property (@(posedge CLOCK) disable iff (RST) tx_brk && tx_trig_wr);
endmodule // lin_brk_ctrl

//--- verilog/lin_brk_pkg.sv
// Constants shared by the baud, break-field and pin control block.
// Assumes one 250 MHz clock and an 8-bit CPU memory bus with 16-bit addresses.
// What this block does
// - Baud divisor k spans 4 to 255; values 0 to 3 are prohibited.
// - Base clock divided by k in an 8-bit counter gives the counter clock.
// - UART bit rate is the counter clock divided by two.
// - DALI bit rate is the counter clock divided by four.
// - Break receive status reads 1 while receiving, 0 after success or when off.
// - A break receive error returns to waiting and keeps the status at 1.
// - Receive trigger reads 0 and clears itself after a good break.
// - Transmit trigger reads 0 and clears itself when the break ends.
// - Break length codes 101..100 give 13 to 20 bit times.
// - A trigger write during a break restarts it; its end raises the done interrupt.
// - Bit order 0 shifts MSB first, 1 shifts LSB first.
// - Transmit invert 1 drives the serial output pin inverted.
// - With invert set the transmit pin is never a general-purpose port.
// - DALI mode ignores break triggers, length, order, invert; status reads 0.
// - Source selects route the serial input to interrupt and capture inputs.
// - Power off stops and resets the unit; enables reset their own circuits.
// - Base clock is the peripheral clock divided by 2 to the n, n 0..10.
package lin_brk_pkg;
	localparam logic [15:0] ADDR_PORT_DIR   = 16'hFF26;
	localparam logic [15:0] ADDR_SRC_SWITCH = 16'hFF4F;
	localparam logic [15:0] ADDR_MODE       = 16'hFF50;
	localparam logic [15:0] ADDR_CLK_SEL    = 16'hFF56;
	localparam logic [15:0] ADDR_BAUD_DIV   = 16'hFF57;
	localparam logic [15:0] ADDR_LIN_CTRL   = 16'hFF58;
	localparam logic [15:0] ADDR_DALI_CTRL  = 16'hFF5F;
	localparam logic [15:0] ADDR_PORT_OTYPE = 16'hFF76;

	localparam logic [7:0] RST_PORT_DIR   = 8'hFF;
	localparam logic [7:0] RST_SRC_SWITCH = 8'h00;
	localparam logic [7:0] RST_MODE       = 8'h01;
	localparam logic [7:0] RST_CLK_SEL    = 8'h00;
	localparam logic [7:0] RST_BAUD_DIV   = 8'hFF;
	localparam logic [7:0] RST_LIN_CTRL   = 8'h16;
	localparam logic [7:0] RST_DALI_CTRL  = 8'h00;
	localparam logic [7:0] RST_PORT_OTYPE = 8'h00;

	localparam int MODE_POWER   = 7;
	localparam int MODE_TXE     = 6;
	localparam int MODE_RXE     = 5;
	localparam int LIN_RX_STAT  = 7;
	localparam int LIN_RX_TRIG  = 6;
	localparam int LIN_TX_TRIG  = 5;
	localparam int LIN_LEN_LSB  = 2;
	localparam int LIN_DIR      = 1;
	localparam int LIN_INV      = 0;
	localparam int SRC_EXT_INT  = 0;
	localparam int SRC_CAPTURE  = 1;
	localparam int PIN_TX       = 0;
	localparam int PIN_RX       = 1;
	localparam int DALI_SEL     = 0;

	localparam logic [7:0] DIV_MIN      = 8'h04;
	localparam logic [3:0] CLK_SEL_MAX  = 4'hA;
	localparam logic [4:0] BRK_RX_MIN   = 5'h0B;
	localparam logic [2:0] BRK_LEN_WRAP = 3'h5;
	localparam logic [4:0] BRK_LEN_LOW  = 5'h08;
	localparam logic [4:0] BRK_LEN_HIGH = 5'h10;
endpackage
